/* File: hdl/see_bus_cond.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// start and stop detection, clocked by the data line itself
module see_bus_cond (
   input wire logic i_scl,
   input wire logic i_sda_i,
   see_prog_if.cond pi
);
   import see_pkg::*;

   logic start_tog_q;
   logic req_tog_q;

   assign pi.start_tog = start_tog_q;
   assign pi.req_tog = req_tog_q;

   // falling data while clock high marks a start
   always_ff @(negedge i_sda_i) begin
      if (pi.link_rst) begin
         start_tog_q <= 1'b0;
      end else if (i_scl) begin
         start_tog_q <= ~start_tog_q;
      end
   end

   // rising data while clock high is a stop; only a stop that ends accepted data asks for programming
   always_ff @(posedge i_sda_i) begin
      if (pi.link_rst) begin
         req_tog_q <= 1'b0;
      end else if (i_scl && pi.armed) begin
         req_tog_q <= ~req_tog_q;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/see_prog_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-timed programming cycle on the system clock
module see_prog_timer #(
   parameter int TWR_CYC = see_pkg::TWR_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   see_prog_if.timer pi,
   output logic o_busy
);
   import see_pkg::*;

   localparam int CNT_W = $clog2(TWR_CYC + 1);
   // busy flag lags the request by one edge, so count one further to keep it high for the full length
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TWR_CYC);

   logic req_meta_q;
   logic req_s_q;
   logic done_q;
   logic busy_q;
   logic [CNT_W-1:0] cnt_q;
   wire busy_now = req_s_q != done_q;
   wire finish = busy_now && (cnt_q == CNT_LAST);

   assign pi.done_tog = done_q;
   assign o_busy = busy_q;

   always_ff @(posedge i_clk) begin
      req_meta_q <= pi.req_tog;
      req_s_q <= req_meta_q;
      if (i_sys_rst) begin
         done_q <= 1'b0;
         busy_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         busy_q <= busy_now && !finish;
         if (finish) begin
            done_q <= req_s_q;
            cnt_q <= '0;
         end else if (busy_now) begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/see_top.sv */
`timescale 1ns/100ps
`default_nettype none
module see_top #(
   parameter int TWR_CYC = see_pkg::TWR_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda_i,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic i_chip_select_input,
   input wire logic i_write_protect,
   output logic o_busy
);
   import see_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
      next_addr = a + ADDR_W'(1);
   endfunction

   function automatic logic [ADDR_W-1:0] next_in_page(input logic [ADDR_W-1:0] a);
      next_in_page = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + PAGE_W'(1)};
   endfunction

   // ==========================================================
   // shared handshake and helper blocks
   see_prog_if pi ();

   see_bus_cond u_cond (
      .i_scl(i_scl),
      .i_sda_i(i_sda_i),
      .pi(pi.cond)
   );

   see_prog_timer #(
      .TWR_CYC(TWR_CYC)
   ) u_timer (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .pi(pi.timer),
      .o_busy(o_busy)
   );

   // ==========================================================
   // link domain synchronisers
   logic rst_meta_q;
   logic rst_link_q;
   logic cs_meta_q;
   logic cs_q;
   logic wp_meta_q;
   logic wp_q;
   logic done_meta_q;
   logic done_s_q;

   // reset only takes effect once the master clocks the bus
   always_ff @(posedge i_scl) begin
      rst_meta_q <= i_sys_rst;
      rst_link_q <= rst_meta_q;
      cs_meta_q <= i_chip_select_input;
      cs_q <= cs_meta_q;
      wp_meta_q <= i_write_protect;
      wp_q <= wp_meta_q;
      done_meta_q <= pi.done_tog;
      done_s_q <= done_meta_q;
   end

   assign pi.link_rst = rst_link_q;

   // ==========================================================
   // link state
   see_state_e state_q;
   logic [3:0] cnt_q;
   logic [6:0] shift_q;
   logic ack_q;
   see_state_e nxt_q;
   logic [1:0] block_q;
   logic [ADDR_W-1:0] ptr_q;
   logic [7:0] tx_q;
   logic armed_q;
   logic start_seen_q;
   logic commit_q;
   logic oe_q;
   logic [PAGE_BYTES-1:0] mask_q;
   logic [7:0] buf_q [PAGE_BYTES];
   logic [7:0] mem_q [MEM_BYTES];

   assign pi.armed = armed_q;

   // ==========================================================
   // decode
   wire start_evt = pi.start_tog != start_seen_q;
   wire see_state_e cur_state = start_evt ? ST_CTRL : state_q;
   wire [3:0] cur_cnt = start_evt ? BIT_FIRST : cnt_q;
   wire [7:0] byte_in = {shift_q, i_sda_i};
   // busy from the stop itself until the done toggle returns, so polls right after stop are refused
   wire link_busy = pi.req_tog != done_s_q;
   wire addr_hit = (byte_in[CODE_HI:CODE_LO] == DEV_CODE) && (byte_in[CS_BIT] == cs_q);
   wire ctrl_ack = addr_hit && !link_busy;
   wire commit_go = pi.req_tog != commit_q;
   wire last_bit = cur_cnt == BIT_LAST;
   wire ack_bit = cur_cnt == BIT_ACK;
   wire [PAGE_W-1:0] page_idx = ptr_q[PAGE_W-1:0];
   wire [7:0] rd_byte = mem_q[ptr_q];
   wire master_ack = !i_sda_i;
   wire drive_ack = ack_q && (state_q != ST_RDATA) && (state_q != ST_IDLE);
   wire oe_d = (cnt_q == BIT_ACK) ? drive_ack : ((state_q == ST_RDATA) && !tx_q[7]);

   // ==========================================================
   // byte engine, sampled on the rising clock edge
   always_ff @(posedge i_scl) begin
      if (rst_link_q) begin
         state_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= BIT_FIRST;
         shift_q <= '0;
         ack_q <= 1'b0;
         block_q <= '0;
         ptr_q <= PTR_RST;
         tx_q <= BYTE_RST;
         armed_q <= 1'b0;
         start_seen_q <= 1'b0;
         commit_q <= 1'b0;
         mask_q <= '0;
      end else begin
         start_seen_q <= pi.start_tog;
         if (commit_go) begin
            commit_q <= pi.req_tog;
         end
         cnt_q <= ack_bit ? BIT_FIRST : cur_cnt + 4'h1;
         shift_q <= byte_in[6:0];
         tx_q <= {tx_q[6:0], 1'b0};
         state_q <= cur_state;
         if (start_evt) begin
            armed_q <= 1'b0;
            mask_q <= '0;
         end
         if (last_bit) begin
            unique case (cur_state)
               ST_CTRL: begin
                  ack_q <= ctrl_ack;
                  block_q <= byte_in[BLK_HI:BLK_LO];
                  nxt_q <= byte_in[RW_BIT] ? ST_RDATA : ST_WADDR;
               end
               ST_WADDR: begin
                  ack_q <= 1'b1;
                  ptr_q <= {block_q, byte_in};
                  nxt_q <= ST_WDATA;
               end
               ST_WDATA: begin
                  ack_q <= !wp_q;
                  nxt_q <= ST_WDATA;
                  if (!wp_q) begin
                     buf_q[page_idx] <= byte_in;
                     mask_q[page_idx] <= 1'b1;
                     armed_q <= 1'b1;
                     ptr_q <= next_in_page(ptr_q);
                  end
               end
               ST_RDATA, ST_IDLE: begin
                  ack_q <= 1'b0;
               end
            endcase
         end
         if (ack_bit) begin
            if (cur_state == ST_RDATA) begin
               if (master_ack) begin
                  tx_q <= rd_byte;
                  ptr_q <= next_addr(ptr_q);
               end else begin
                  state_q <= ST_IDLE;
               end
            end else if (ack_q && cur_state != ST_IDLE) begin
               state_q <= nxt_q;
               if (nxt_q == ST_RDATA) begin
                  tx_q <= rd_byte;
                  ptr_q <= next_addr(ptr_q);
               end
            end else begin
               state_q <= ST_IDLE;
            end
         end
      end
   end

   // ==========================================================
   // commit of the page buffer
   // array is written on the first rising bus clock edge after the stop; reads stay refused until the cycle ends
   always_ff @(posedge i_scl) begin
      if (commit_go) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (mask_q[i]) begin
               mem_q[{ptr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= buf_q[i];
            end
         end
      end
   end

   // ==========================================================
   // data line driver, changes only while the clock is low
   always_ff @(negedge i_scl) begin
      if (rst_link_q) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   assign o_sda_o = 1'b0;
   assign o_sda_oe = oe_q;

endmodule
`default_nettype wire

/* File: include/see_pkg.sv */
`default_nettype none
package see_pkg;

   // ==========================================================
   // array and page geometry
   localparam int ADDR_W = 10;
   localparam int PAGE_W = 4;
   localparam int PAGE_BYTES = 16;
   localparam int MEM_BYTES = 1024;

   // ==========================================================
   // slave address layout
   localparam logic [3:0] DEV_CODE = 4'ha;
   localparam int CODE_HI = 7;
   localparam int CODE_LO = 4;
   localparam int CS_BIT = 3;
   localparam int BLK_HI = 2;
   localparam int BLK_LO = 1;
   localparam int RW_BIT = 0;

   // ==========================================================
   // bit positions within one nine-clock byte slot
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   // ==========================================================
   // reset values
   localparam logic [ADDR_W-1:0] PTR_RST = 10'h000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ==========================================================
   // programming cycle timing
   localparam longint CLK_HZ = 10_000_000;
   localparam longint TWR_MS = 10;
   localparam int TWR_CYCLES = int'((CLK_HZ * TWR_MS) / 1000);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CTRL,
      ST_WADDR,
      ST_WDATA,
      ST_RDATA
   } see_state_e;

endpackage
`default_nettype wire

/* File: include/see_prog_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bus conditions and programming handshake
interface see_prog_if;
   logic link_rst;
   logic start_tog;
   logic req_tog;
   logic done_tog;
   logic armed;

   modport link (
      output link_rst,
      output armed,
      input start_tog,
      input req_tog,
      input done_tog
   );
   modport cond (
      input link_rst,
      input armed,
      output start_tog,
      output req_tog
   );
   modport timer (
      input req_tog,
      output done_tog
   );
endinterface
`default_nettype wire

/* File: verification/see_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bus master: clock stands high between frames
module see_bus_master (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_pull
);
   initial begin
      o_scl = 1'b1;
      o_pull = 1'b0;
   end
   // sda pulse with clock low arms start detection in reset
   task automatic wake(input int n, input logic tog);
      repeat (n) begin
         #80 o_scl = 1'b0;
         o_pull = tog;
         #40 o_pull = 1'b0;
         #40 o_scl = 1'b1;
      end
   endtask
   task automatic start;
      o_pull = 1'b0;
      #40 o_scl = 1'b1;
      #40 o_pull = 1'b1;
      #40 o_scl = 1'b0;
      #40;
   endtask
   task automatic stop;
      o_pull = 1'b1;
      #40 o_scl = 1'b1;
      #40 o_pull = 1'b0;
      #80;
   endtask
   // nine bits, msb first; a one releases the line
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         o_pull = !d[i];
         #40 o_scl = 1'b1;
         #40 q[i] = i_sda;
         #40 o_scl = 1'b0;
         #40;
      end
      o_pull = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: verification/see_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module see_top_monitor
   import see_pkg::*;
#(
   parameter int TWR_CYC = 50
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda_i,
   input wire logic o_sda_o,
   input wire logic o_sda_oe,
   input wire logic i_chip_select_input,
   input wire logic i_write_protect,
   input wire logic o_busy
);
   // ==========================================================
   // frame tracking
   logic st_t = 1'b0;
   logic st_s = 1'b0;
   logic b0_q = 1'b0;
   logic [3:0] bc_q = 4'h0;
   logic [7:0] sh_q = 8'h00;
   int cnt_q = 0;
   wire nw = st_t != st_s;
   wire ctl9 = b0_q && bc_q == 4'h8;
   wire hit = sh_q[7:4] == DEV_CODE && sh_q[3] == i_chip_select_input;
   always_ff @(negedge i_sda_i) begin
      if (i_scl)
         st_t <= ~st_t;
   end
   always_ff @(posedge i_scl) begin
      st_s <= st_t;
      sh_q <= {sh_q[6:0], i_sda_i};
      bc_q <= (nw || bc_q == 4'h9) ? 4'h1 : bc_q + 4'h1;
      b0_q <= nw || (b0_q && bc_q != 4'h9);
   end
   always_ff @(posedge i_clk) begin
      cnt_q <= o_busy ? cnt_q + 1 : 0;
   end
   // ==========================================================
   // checks
   drain_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) o_sda_o == 1'b0)
      else $error("data output not low");
   busy_quiet_a: assert property (@(posedge i_scl) disable iff (i_sys_rst) o_busy |-> !o_sda_oe)
      else $error("bus driven while programming");
   busy_len_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) $fell(o_busy) |-> cnt_q == TWR_CYC)
      else $error("programming length wrong");
   busy_max_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) o_busy |-> cnt_q < TWR_CYC)
      else $error("programming too long");
   wp_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_write_protect && $past(i_write_protect, 8) |-> !$rose(o_busy))
      else $error("programming while protected");
   addr_nack_a: assert property (@(posedge i_scl) disable iff (i_sys_rst) ctl9 && !hit |-> !o_sda_oe)
      else $error("foreign address acked");
   addr_ack_a: assert property (@(posedge i_scl) disable iff (i_sys_rst)
      ctl9 && hit && !o_busy && !$past(o_busy, 6) |-> o_sda_oe)
      else $error("own address not acked");
   ctl_quiet_a: assert property (@(posedge i_scl) disable iff (i_sys_rst)
      b0_q && bc_q inside {[4'h1:4'h7]} |-> !o_sda_oe)
      else $error("bus driven in control byte");
   cover property (@(posedge i_clk) $rose(o_busy));
   cover property (@(posedge i_scl) ctl9 && o_sda_oe);
   cover property (@(posedge i_scl) ctl9 && !o_sda_oe);
endmodule
bind see_top see_top_monitor #(.TWR_CYC(TWR_CYC)) see_top_monitor_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_scl(i_scl), .i_sda_i(i_sda_i), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
   .i_chip_select_input(i_chip_select_input), .i_write_protect(i_write_protect), .o_busy(o_busy));
`default_nettype wire

/* File: verification/see_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module see_top_test;
   import see_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs = 1'b1;
   logic wp = 1'b0;
   wire scl;
   wire pull;
   wire oe;
   wire so;
   wire busy;
   // open drain with pull-up
   wire sda = !pull & (oe ? so : 1'b1);
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] em [1024];
   logic [9:0] ep = 10'h000;
   see_top #(.TWR_CYC(50)) see_top_inst (.i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda_i(sda),
      .o_sda_o(so), .o_sda_oe(oe), .i_chip_select_input(cs), .i_write_protect(wp), .o_busy(busy));
   see_bus_master see_bus_master_inst (.i_sda(sda), .o_scl(scl), .o_pull(pull));
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         test_done();
      end
   end
   // ==========================================================
   // compare and bus tasks
   task automatic tally(input logic bad);
      n_checks++;
      if (bad) begin
         errors++;
         $display("Error at %0t ns: mismatch", $time);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      tally(got !== exp);
   endtask
   task automatic chk_d(input logic [7:0] got, input logic [7:0] exp);
      tally(got !== exp);
   endtask
   task automatic ctl(input logic r, input logic [9:0] a, input logic c, input logic ak);
      logic [8:0] q;
      see_bus_master_inst.start();
      see_bus_master_inst.xfer({DEV_CODE, c, a[9:8], r, 1'b1}, q);
      chk_b(q[0], !ak);
   endtask
   task automatic wr(input logic [9:0] a, input int n, input logic [7:0] b);
      logic [8:0] q;
      ctl(1'b0, a, cs, 1'b1);
      see_bus_master_inst.xfer({a[7:0], 1'b1}, q);
      chk_b(q[0], 1'b0);
      for (int i = 0; i < n; i++) begin
         see_bus_master_inst.xfer({b + 8'(i), 1'b1}, q);
         chk_b(q[0], wp);
         if (!wp)
            em[{a[9:4], a[3:0] + 4'(i)}] = b + 8'(i);
      end
      if (!wp)
         ep = {a[9:4], a[3:0] + 4'(n)};
      see_bus_master_inst.stop();
   endtask
   task automatic rd(input logic rnd, input logic [9:0] a, input int n);
      logic [8:0] q;
      if (rnd) begin
         ctl(1'b0, a, cs, 1'b1);
         see_bus_master_inst.xfer({a[7:0], 1'b1}, q);
         ep = a;
      end
      ctl(1'b1, ep, cs, 1'b1);
      for (int i = 0; i < n; i++) begin
         see_bus_master_inst.xfer({8'hff, i == n - 1}, q);
         chk_d(q[8:1], em[ep]);
         ep = ep + 10'h001;
      end
      see_bus_master_inst.stop();
   endtask
   task automatic poll(output int k);
      logic [8:0] q;
      k = 0;
      q = 9'h001;
      while (q[0] && k < 100) begin
         see_bus_master_inst.start();
         see_bus_master_inst.xfer({DEV_CODE, cs, 3'b000, 1'b1}, q);
         see_bus_master_inst.stop();
         k++;
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic t_byte;
      int k;
      wr(10'h155, 1, 8'h3c);
      repeat (5) @(negedge clk);
      chk_b(busy, 1'b1);
      poll(k);
      chk_b(k > 1 && k < 100, 1'b1);
      rd(1'b1, 10'h155, 1);
      $display("byte write test done");
   endtask
   task automatic t_page;
      int k;
      wr(10'h23e, 17, 8'h40);
      poll(k);
      rd(1'b0, 10'h000, 1);
      rd(1'b1, 10'h230, 16);
      $display("page write test done");
   endtask
   task automatic t_wrap;
      int k;
      wr(10'h3ff, 1, 8'h5a);
      poll(k);
      wr(10'h000, 1, 8'ha5);
      poll(k);
      rd(1'b1, 10'h3ff, 2);
      repeat (5) @(negedge clk);
      chk_b(busy, 1'b0);
      $display("read wrap test done");
   endtask
   task automatic t_prot;
      @(negedge clk);
      wp = 1'b1;
      wr(10'h155, 1, 8'hc3);
      repeat (5) @(negedge clk);
      chk_b(busy, 1'b0);
      wp = 1'b0;
      rd(1'b1, 10'h155, 1);
      $display("protect test done");
   endtask
   task automatic t_addr;
      ctl(1'b0, 10'h000, !cs, 1'b0);
      see_bus_master_inst.stop();
      @(negedge clk);
      cs = 1'b0;
      ctl(1'b0, 10'h000, 1'b0, 1'b1);
      see_bus_master_inst.stop();
      $display("address test done");
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      see_bus_master_inst.wake(5, 1'b1);
      @(negedge clk);
      rst = 1'b0;
      see_bus_master_inst.wake(3, 1'b0);
      t_byte();
      t_page();
      t_wrap();
      t_prot();
      t_addr();
      test_done();
   end
endmodule
`default_nettype wire
